/* shared/dosc_consts.vh */
// Constants for the dual oscillator clock select block.
// Assumes inclusion by bare name from the design files.
`ifndef DOSC_CONSTS_VH
`define DOSC_CONSTS_VH
`define DOSC_ADDR_W          16
`define DOSC_DATA_W          8
`define DOSC_OFF_SUB_OSC     16'hFFF0
`define DOSC_OFF_SUBCLK_CTRL 16'hFFF2
`define DOSC_OFF_PROC_CLK    16'hFFFB
`define DOSC_RST_SUB_OSC     8'h00
`define DOSC_RST_SUBCLK_CTRL 8'h00
`define DOSC_RST_PROC_CLK    8'h02
`define DOSC_BIT_FB_RES_OFF  1
`define DOSC_BIT_SUB_STOP    0
`define DOSC_BIT_STATUS      5
`define DOSC_BIT_SUB_SEL     4
`define DOSC_BIT_MAIN_DIV    1
`define DOSC_BIT_MAIN_STOP   7
`define DOSC_MASK_SUB_OSC    8'h03
`define DOSC_MASK_SUBCLK     8'h10
`define DOSC_MASK_PROC_CLK   8'h82
`define DOSC_READ_ZERO       8'h00
`define DOSC_DIV_W           2
`define DOSC_DIV_FOUR_TOP    2'h3
`define DOSC_SRC_MAIN_FULL   2'h0
`define DOSC_SRC_MAIN_QUART  2'h1
`define DOSC_SRC_SUB_HALF    2'h2
`define DOSC_SYNC_STAGES     2
`define DOSC_PERIPH_DIV_W    4
`endif

/* src/dosc_clock_select.v */
// Clock generator control: oscillator enables, feedback resistor, CPU clock choice.
// Assumes one register port, synchronous inputs, and oscillator ticks as level inputs.
//
// Summary of operation
// - Reset clears the sub oscillator mode register to zero.
// - Bit 1 high disconnects the sub oscillator feedback resistor.
// - Bit 0 high stops the sub oscillator.
// - Reset clears the subclock control register, selecting divided main clock.
// - Bit 5 of subclock control is read-only CPU clock status.
// - Bit 4 of subclock control selects main or sub clock source.
// - Reset puts processor clock control at 02H, slow main clock.
// - Main oscillator stays stopped while reset is asserted.
// - Three CPU clock periods: two main-derived, one sub-derived.
// - fx, fx over 4, or sub clock over 2 by select bits.
// - With main clock, both STOP and HALT are permitted.
// - With sub clock, main stop bit works; HALT allowed, STOP not.
// - Sub clock selection gives the low power CPU mode.
// - Peripheral clock enable pulses on every main oscillator tick, off in STOP.
// - Sub clock feeds the CPU (sub over 2) and the sub peripheral enable for clock out, LCD and watch timer.
//
// Our own choice: the plain strobed port.
`default_nettype none
`include "dosc_consts.vh"
module dosc_clock_select (
    input  wire                         i_ref_clk,
    input  wire                         i_reset,
    input  wire [`DOSC_ADDR_W-1:0]      i_addr,
    input  wire [`DOSC_DATA_W-1:0]      i_wdata,
    input  wire                         i_wr,
    input  wire                         i_rd,
    input  wire                         i_main_osc_tick,
    input  wire                         i_sub_osc_tick,
    input  wire                         i_stop_req,
    input  wire                         i_halt_req,
    output reg  [`DOSC_DATA_W-1:0]      o_rdata,
    output reg                          o_main_osc_run,
    output reg                          o_sub_osc_run,
    output reg                          o_feedback_res_on,
    output reg                          o_cpu_clk_en,
    output reg                          o_periph_clk_en,
    output reg                          o_sub_periph_clk_en,
    output reg                          o_stop_ok,
    output reg                          o_halt_ok,
    output reg                          o_low_power
);
    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    function is_addr;
        input [`DOSC_ADDR_W-1:0] a;
        input [`DOSC_ADDR_W-1:0] off;
        begin
            is_addr = (a == off);
        end
    endfunction

    reg [`DOSC_DATA_W-1:0] sub_osc_mode_q;
    reg [`DOSC_DATA_W-1:0] subclk_ctrl_q;
    reg [`DOSC_DATA_W-1:0] proc_clk_q;
    reg                    cpu_clk_status_q;
    reg [`DOSC_DIV_W-1:0]  src_q;
    reg [`DOSC_DIV_W-1:0]  div_q;
    reg [`DOSC_PERIPH_DIV_W-1:0] periph_div_q;
    reg                    sub_half_q;
    reg                    main_tick_prev_q;
    reg                    sub_tick_prev_q;
    wire                   main_tick_s;
    wire                   sub_tick_s;

    wire sub_clk_select  = subclk_ctrl_q[`DOSC_BIT_SUB_SEL];
    wire main_div_select = proc_clk_q[`DOSC_BIT_MAIN_DIV];
    wire main_osc_stop   = proc_clk_q[`DOSC_BIT_MAIN_STOP];
    wire sub_osc_stop    = sub_osc_mode_q[`DOSC_BIT_SUB_STOP];
    wire feedback_res_off = sub_osc_mode_q[`DOSC_BIT_FB_RES_OFF];
    wire main_rise = main_tick_s & ~main_tick_prev_q;
    wire sub_rise  = sub_tick_s & ~sub_tick_prev_q;

    // Oscillator ticks are asynchronous in a real chip, so they are synchronised
    dosc_sync u_main_sync (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_level   (i_main_osc_tick),
        .o_level   (main_tick_s)
    );
    dosc_sync u_sub_sync (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_level   (i_sub_osc_tick),
        .o_level   (sub_tick_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; reserved bits masked so they always read zero
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            sub_osc_mode_q <= `DOSC_RST_SUB_OSC;
            subclk_ctrl_q  <= `DOSC_RST_SUBCLK_CTRL;
            proc_clk_q     <= `DOSC_RST_PROC_CLK;
        end else if (i_wr) begin
            if (is_addr(i_addr, `DOSC_OFF_SUB_OSC)) begin
                sub_osc_mode_q <= i_wdata & `DOSC_MASK_SUB_OSC;
            end
            if (is_addr(i_addr, `DOSC_OFF_SUBCLK_CTRL)) begin
                subclk_ctrl_q <= i_wdata & `DOSC_MASK_SUBCLK;
            end
            if (is_addr(i_addr, `DOSC_OFF_PROC_CLK)) begin
                proc_clk_q <= i_wdata & `DOSC_MASK_PROC_CLK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data stands one cycle after the strobe only
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rdata <= `DOSC_READ_ZERO;
        end else if (i_rd) begin
            if (is_addr(i_addr, `DOSC_OFF_SUB_OSC)) begin
                o_rdata <= sub_osc_mode_q;
            end else if (is_addr(i_addr, `DOSC_OFF_SUBCLK_CTRL)) begin
                o_rdata <= subclk_ctrl_q
                         | ({{(`DOSC_DATA_W-1){1'b0}}, cpu_clk_status_q}
                            << `DOSC_BIT_STATUS);
            end else if (is_addr(i_addr, `DOSC_OFF_PROC_CLK)) begin
                o_rdata <= proc_clk_q;
            end else begin
                o_rdata <= `DOSC_READ_ZERO;
            end
        end else begin
            o_rdata <= `DOSC_READ_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU clock source mux; switches only on an edge of the target clock
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            main_tick_prev_q <= 1'b0;
            sub_tick_prev_q  <= 1'b0;
            src_q            <= `DOSC_SRC_MAIN_QUART;
            cpu_clk_status_q <= 1'b0;
        end else begin
            main_tick_prev_q <= main_tick_s;
            sub_tick_prev_q  <= sub_tick_s;
            if (sub_clk_select && sub_rise && src_q != `DOSC_SRC_SUB_HALF) begin
                src_q            <= `DOSC_SRC_SUB_HALF;
                cpu_clk_status_q <= 1'b1;
            end else if (!sub_clk_select && main_rise) begin
                // Status tracks the mux, not the select bit
                src_q <= main_div_select ? `DOSC_SRC_MAIN_QUART
                                         : `DOSC_SRC_MAIN_FULL;
                cpu_clk_status_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Dividers: fx/4 from main ticks, sub_osc_freq/2 from sub ticks
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            div_q        <= {`DOSC_DIV_W{1'b0}};
            sub_half_q   <= 1'b0;
            periph_div_q <= {`DOSC_PERIPH_DIV_W{1'b0}};
        end else begin
            if (main_rise && o_main_osc_run) begin
                div_q        <= div_q + 1'b1;
                periph_div_q <= periph_div_q + 1'b1;
            end
            if (sub_rise && o_sub_osc_run) begin
                sub_half_q <= ~sub_half_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator controls, clock enables and standby permissions
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_main_osc_run      <= 1'b0;
            o_sub_osc_run       <= 1'b0;
            o_feedback_res_on   <= 1'b0;
            o_cpu_clk_en        <= 1'b0;
            o_periph_clk_en     <= 1'b0;
            o_sub_periph_clk_en <= 1'b0;
            o_stop_ok           <= 1'b0;
            o_halt_ok           <= 1'b0;
            o_low_power         <= 1'b0;
        end else begin
            // Main stop honoured only with the sub clock running the CPU
            o_main_osc_run    <= ~(main_osc_stop & cpu_clk_status_q);
            o_sub_osc_run     <= ~sub_osc_stop;
            o_feedback_res_on <= ~feedback_res_off;
            case (src_q)
                `DOSC_SRC_MAIN_FULL:  o_cpu_clk_en <= main_rise & o_main_osc_run;
                `DOSC_SRC_MAIN_QUART: o_cpu_clk_en <= main_rise & o_main_osc_run
                                                      & (div_q == `DOSC_DIV_FOUR_TOP);
                `DOSC_SRC_SUB_HALF:   o_cpu_clk_en <= sub_rise & o_sub_osc_run
                                                      & sub_half_q;
                default:              o_cpu_clk_en <= 1'b0;
            endcase
            o_periph_clk_en     <= main_rise & o_main_osc_run & ~i_stop_req;
            o_sub_periph_clk_en <= sub_rise & o_sub_osc_run;
            o_stop_ok           <= ~cpu_clk_status_q;
            o_halt_ok           <= 1'b1;
            o_low_power         <= cpu_clk_status_q & ~i_halt_req;
        end
    end
endmodule // dosc_clock_select
`default_nettype wire

/* src/dosc_sync.v */
// Two-stage level synchroniser for one bit, generate based.
// Assumes the input level may come from another oscillator domain.
`default_nettype none
`include "dosc_consts.vh"
module dosc_sync (
    input  wire i_ref_clk,
    input  wire i_reset,
    input  wire i_level,
    output wire o_level
);
    reg [`DOSC_SYNC_STAGES-1:0] stage_q;
    genvar g;
    generate
        for (g = 0; g < `DOSC_SYNC_STAGES; g = g + 1) begin : g_stage
            always @(posedge i_ref_clk) begin
                if (i_reset) begin
                    stage_q[g] <= 1'b0;
                end else begin
                    stage_q[g] <= (g == 0) ? i_level : stage_q[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate
    assign o_level = stage_q[`DOSC_SYNC_STAGES-1];
endmodule // dosc_sync
`default_nettype wire

/* tb/dosc_clock_select_checker.sv */
// Checker for the clock select block, ports only.
// Assumes a bind onto dosc_clock_select and the shared constants.
`default_nettype none
`include "dosc_consts.vh"
module dosc_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_reset,
    input wire logic [15:0] i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic        i_stop_req,
    input wire logic        i_halt_req,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_main_osc_run,
    input wire logic        o_sub_osc_run,
    input wire logic        o_feedback_res_on,
    input wire logic        o_periph_clk_en,
    input wire logic        o_stop_ok,
    input wire logic        o_halt_ok,
    input wire logic        o_low_power
);
default clocking cb @(posedge i_ref_clk); endclocking
default disable iff (i_reset);
wire logic w_mode = i_wr && i_addr == `DOSC_OFF_SUB_OSC;
////////////////////////////////////////////////////////////////////////////////
a_reset_main_off: assert property ($fell(i_reset) |-> !o_main_osc_run)
    else $error("main oscillator ran out of reset");
a_sub_osc_ctl: assert property ($past(w_mode, 2) && !$past(i_reset)
    |-> o_sub_osc_run == !$past(i_wdata[0], 2)) else $error("sub stop bit ignored");
a_fb_res_ctl: assert property ($past(w_mode, 2) && !$past(i_reset)
    |-> o_feedback_res_on == !$past(i_wdata[1], 2)) else $error("resistor bit ignored");
a_mode_mask: assert property ($past(i_rd) && $past(i_addr) == `DOSC_OFF_SUB_OSC
    |-> o_rdata[7:2] == 6'h00) else $error("mode reserved bits set");
a_css_mask: assert property ($past(i_rd) && $past(i_addr) == `DOSC_OFF_SUBCLK_CTRL
    |-> (o_rdata & 8'hCF) == 8'h00) else $error("subclock reserved bits set");
a_main_guard: assert property (o_stop_ok |-> o_main_osc_run)
    else $error("main oscillator stopped on main clock");
a_halt_ok: assert property (!$past(i_reset) |-> o_halt_ok)
    else $error("halt not permitted");
a_halt_lp: assert property (i_halt_req |=> !o_low_power)
    else $error("low power flag during halt");
a_stop_gate: assert property (i_stop_req |=> !o_periph_clk_en)
    else $error("peripheral clock during stop");
c_low_power: cover property (o_low_power);
c_mode_wr: cover property (w_mode);
c_stop: cover property (i_stop_req && o_stop_ok);
endmodule // dosc_checker
bind dosc_clock_select dosc_checker u_chk (.*);
`default_nettype wire

/* tb/test_dosc_clock_select.sv */
// Register-level bench for the clock select block.
// Assumes oscillator levels made here; main stalls while stopped.
`default_nettype none
module test_dosc_clock_select;
timeunit 1ns;
timeprecision 100ps;
logic clk = 0, rst = 1, wr = 0, rd = 0, mt = 0, st = 0, sr = 0, hr = 0;
logic [15:0] addr = 16'h0000;
logic [7:0] wd = 8'h00, got;
wire logic [7:0] rdat;
wire logic mrun, srun, fb, cen, pen, spen, sok, hok, lp;
int fail_count = 0, samples_checked = 0, nc, np, ns, sc = 0;
dosc_clock_select uut (.i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .i_main_osc_tick(mt), .i_sub_osc_tick(st), .i_stop_req(sr),
    .i_halt_req(hr), .o_rdata(rdat), .o_main_osc_run(mrun), .o_sub_osc_run(srun),
    .o_feedback_res_on(fb), .o_cpu_clk_en(cen), .o_periph_clk_en(pen),
    .o_sub_periph_clk_en(spen), .o_stop_ok(sok), .o_halt_ok(hok), .o_low_power(lp));
always #2.5 clk = ~clk;
// Stopped main oscillator must not tick
always @(posedge clk) begin
    if (mrun) mt <= ~mt;
    sc <= (sc == 19) ? 0 : sc + 1;
    if (sc == 19) st <= ~st;
end
////////////////////////////////////////////////////////////////////////////////
task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        fail_count++;
        $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
endtask
task wrr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
endtask
task rdr(input logic [15:0] a);
    @(posedge clk);
    addr <= a; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 got = rdat;
endtask
task run(input int n);
    nc = 0; np = 0; ns = 0;
    repeat (n) begin
        @(posedge clk);
        #1 nc += cen; np += pen; ns += spen;
    end
endtask
task poll(input logic b);
    repeat (80) begin
        rdr(16'hFFF2);
        if (got[5] === b) break;
    end
endtask
task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
initial begin
    #200000 fail_count++;
    tally_and_finish;
end
initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rdr(16'hFFF0); chk("mode", got, 8'h00);
    rdr(16'hFFF2); chk("css", got, 8'h00);
    rdr(16'hFFFB); chk("pcc", got, 8'h02);
    rdr(16'hFFF4); chk("unmapped", got, 8'h00);
    wrr(16'hFFFB, 8'h82); run(4); chk("main guard", mrun, 1);
    run(400); chk("fx/4", nc inside {[49:51]}, 1); chk("periph", np inside {[199:201]}, 1);
    wrr(16'hFFFB, 8'h00); run(400); chk("fx", nc inside {[199:201]}, 1);
    @(posedge clk) sr <= 1;
    // Peripheral enable is registered; let the last pre-stop pulse pass
    @(posedge clk);
    run(100); chk("stop periph", np, 0); chk("stop ok", sok, 1);
    @(posedge clk) sr <= 0;
    // Sub oscillator here is a crystal model, so its stop bit may be set
    wrr(16'hFFF0, 8'hFF);
    run(2); chk("sub run", srun, 0); chk("fb", fb, 0);
    rdr(16'hFFF0); chk("mode mask", got, 8'h03);
    wrr(16'hFFF0, 8'h00); run(2); chk("sub run", srun, 1);
    wrr(16'hFFF2, 8'hFF); rdr(16'hFFF2); chk("css early", got, 8'h10);
    poll(1); chk("css", got, 8'h30); chk("lp", lp, 1); chk("stop ok", sok, 0);
    run(800); chk("sub/2", nc inside {[9:11]}, 1); chk("sub per", ns inside {[19:21]}, 1);
    // Main stop only after the sub clock runs the CPU; main is a crystal
    wrr(16'hFFFB, 8'h80);
    run(10); chk("main stop", mrun, 0);
    run(200); chk("periph off", np, 0); chk("sub on", ns inside {[4:6]}, 1);
    @(posedge clk) hr <= 1;
    run(4); chk("halt lp", lp, 0); chk("halt ok", hok, 1);
    @(posedge clk) hr <= 0;
    wrr(16'hFFFB, 8'h02); run(20); wrr(16'hFFF2, 8'h00);
    poll(0); chk("css back", got, 8'h00); chk("stop ok", sok, 1);
    tally_and_finish;
end
endmodule // test_dosc_clock_select
`default_nettype wire
